// >>> logic/osc_select_ctrl.v
// Oscillator selection control with APB registers and clock switch
// How it works
// - decode next source: FAST_RC_OSC div, PLL, primary, sec, LOW_POWER_RC_OSC
// - codes 110 and 111 act as 000
// - reset loads next source from config bits
// - lock bit blocks next source writes and switch requests
// - wait enters Sleep if enabled, else Idle
// - fail flag set by clock monitor
// - secondary oscillator runs while enable is one
// - switch request starts switch, clears when done
// - control writes need prior unlock sequence
// - reset loads secondary enable from config
`timescale 1ns/100ps
`include "osc_defs.vh"
module osc_select_ctrl (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // APB slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output reg [31:0] prdata,
    output wire pslverr,
    // Nonvolatile configuration
    input wire [2:0] initial_source_config,
    input wire cfg_secondary_osc_enable,
    // Oscillator ready levels, one per source code, asynchronous
    input wire [7:0] osc_ready,
    // Fail-safe clock monitor, asynchronous level
    input wire fail_safe_clock_monitor,
    // Wait instruction from the core
    input wire wait_exec,
    // Clock tree controls
    output reg [2:0] active_source,
    output reg [7:0] source_run,
    output reg clk_gate_hold,
    output reg secondary_osc_run,
    output reg sleep_req,
    output reg idle_req,
    // Interrupt
    output wire irq
);
    // ======================================================
    // State
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT_RDY = 2'h1;
    localparam ST_HOLD = 2'h2;
    localparam ST_SWAP = 2'h3;

    reg [2:0] nsel_q;
    reg lock_q;
    reg sleep_en_q;
    reg fail_q;
    reg sec_en_q;
    reg swreq_q;
    reg [1:0] unlock_q;
    reg [1:0] st_q;
    reg [1:0] st_d;
    reg [2:0] target_q;
    reg [`OSC_CNT_W-1:0] cnt_q;
    reg [`OSC_IRQ_W-1:0] irq_stat_q;
    reg [`OSC_IRQ_W-1:0] irq_en_q;
    reg cfg_loaded_q;
    reg fail_seen_q;
    wire [7:0] rdy_s;
    wire fail_s;
    wire [2:0] nsel_dec;
    wire wr;
    wire rd;
    wire ctrl_wr;
    wire ctrl_ok;
    wire sw_done;
    wire [31:0] ctrl_rd;
    wire [31:0] ready_cyc;

    // ======================================================
    // Input synchronisers
    osc_sync2 #(.W(9)) u_sync (
        .mclk(mclk),
        .rstn(rstn),
        .async_in({fail_safe_clock_monitor, osc_ready}),
        .sync_out({fail_s, rdy_s})
    );

    // ======================================================
    // Bus decode; zero wait states, no errors
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    // Settle count, cut to the counter width where it is loaded
    assign ready_cyc = `OSC_READY_CYC;
    assign wr = psel & penable & pwrite;
    assign rd = psel & ~pwrite;
    assign ctrl_wr = wr & (paddr == `OSC_CTRL_OFF);
    assign ctrl_ok = ctrl_wr & (unlock_q == 2'h2);

    // Codes 6 and 7 fall back to the divided fast RC; reserved code 3 passes through
    assign nsel_dec = (nsel_q[2] & nsel_q[1]) ? `OSC_SRC_FAST_RC_POSTDIVIDER
                    : nsel_q;

    assign ctrl_rd = {21'h0, nsel_q, lock_q, 2'h0, sleep_en_q, fail_q,
                      1'b0, sec_en_q, swreq_q};

    // ======================================================
    // Unlock sequence: key1, key2, then one control write
    always @(posedge mclk) begin
        if (!rstn) begin
            unlock_q <= 2'h0;
        end else if (wr && paddr == `OSC_UNLOCK_OFF) begin
            if (pwdata == `OSC_KEY1) begin
                unlock_q <= 2'h1;
            end else if (pwdata == `OSC_KEY2 && unlock_q == 2'h1) begin
                unlock_q <= 2'h2;
            end else begin
                unlock_q <= 2'h0;
            end
        end else if (ctrl_wr) begin
            // Any control write spends the unlock, valid or not
            unlock_q <= 2'h0;
        end
    end

    // ======================================================
    // Control register
    always @(posedge mclk) begin
        if (!rstn) begin
            nsel_q <= `OSC_SRC_FAST_RC_POSTDIVIDER;
            lock_q <= 1'b0;
            sleep_en_q <= 1'b0;
            sec_en_q <= 1'b0;
            cfg_loaded_q <= 1'b0;
        end else if (!cfg_loaded_q) begin
            // Config straps caught on the first edge after reset
            nsel_q <= initial_source_config;
            sec_en_q <= cfg_secondary_osc_enable;
            cfg_loaded_q <= 1'b1;
        end else if (ctrl_ok) begin
            if (!lock_q) begin
                nsel_q <= pwdata[`OSC_NSEL_HI:`OSC_NSEL_LO];
            end
            // Lock is sticky until reset
            lock_q <= lock_q | pwdata[`OSC_LOCK_BIT];
            sleep_en_q <= pwdata[`OSC_SLEEP_BIT];
            sec_en_q <= pwdata[`OSC_SEC_EN_BIT];
        end
    end

    // ======================================================
    // Switch request; set wins over done
    assign sw_done = (st_q == ST_SWAP);
    always @(posedge mclk) begin
        if (!rstn) begin
            swreq_q <= 1'b0;
        end else if (ctrl_ok && pwdata[`OSC_SWREQ_BIT] && !lock_q) begin
            swreq_q <= 1'b1;
        end else if (sw_done) begin
            swreq_q <= 1'b0;
        end
    end

    // ======================================================
    // Switch sequencer
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (swreq_q) begin
                    st_d = ST_WAIT_RDY;
                end
            end
            ST_WAIT_RDY: begin
                // Old source keeps running meanwhile
                if (rdy_s[target_q]) begin
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_q == {`OSC_CNT_W{1'b0}}) begin
                    st_d = ST_SWAP;
                end
            end
            ST_SWAP: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge mclk) begin
        if (!rstn) begin
            st_q <= ST_IDLE;
            target_q <= `OSC_SRC_FAST_RC_POSTDIVIDER;
            cnt_q <= {`OSC_CNT_W{1'b0}};
            active_source <= `OSC_SRC_FAST_RC_POSTDIVIDER;
            clk_gate_hold <= 1'b0;
        end else begin
            st_q <= st_d;
            if (!cfg_loaded_q) begin
                active_source <= (initial_source_config[2] &
                    initial_source_config[1]) ? `OSC_SRC_FAST_RC_POSTDIVIDER
                    : initial_source_config;
            end
            if (st_q == ST_IDLE && swreq_q) begin
                target_q <= nsel_dec;
            end
            if (st_q == ST_WAIT_RDY && st_d == ST_HOLD) begin
                // Gate held low for a settle time so no runt pulse
                clk_gate_hold <= 1'b1;
                cnt_q <= ready_cyc[`OSC_CNT_W-1:0];
            end else if (st_q == ST_HOLD && cnt_q != {`OSC_CNT_W{1'b0}}) begin
                cnt_q <= cnt_q - 1'b1;
            end
            if (st_q == ST_SWAP) begin
                active_source <= target_q;
                clk_gate_hold <= 1'b0;
            end
        end
    end

    // ======================================================
    // Oscillator run enables
    genvar g;
    generate
        for (g = 0; g < 8; g = g + 1) begin : g_run
            always @(posedge mclk) begin
                if (!rstn) begin
                    source_run[g] <= 1'b0;
                end else begin
                    // Reserved code 3 never runs
                    source_run[g] <= (g != 3) &&
                        ((active_source == g) ||
                         (st_q != ST_IDLE && target_q == g) ||
                         (g == `OSC_SRC_SEC && sec_en_q));
                end
            end
        end
    endgenerate

    always @(posedge mclk) begin
        if (!rstn) begin
            secondary_osc_run <= 1'b0;
        end else begin
            secondary_osc_run <= sec_en_q;
        end
    end

    // ======================================================
    // Power mode on wait
    always @(posedge mclk) begin
        if (!rstn) begin
            sleep_req <= 1'b0;
            idle_req <= 1'b0;
        end else begin
            sleep_req <= wait_exec & sleep_en_q;
            idle_req <= wait_exec & ~sleep_en_q;
        end
    end

    // ======================================================
    // Clock fail flag, cleared only by reset
    always @(posedge mclk) begin
        if (!rstn) begin
            fail_q <= 1'b0;
            fail_seen_q <= 1'b0;
        end else begin
            fail_seen_q <= fail_s;
            if (fail_s) begin
                fail_q <= 1'b1;
            end
        end
    end

    // ======================================================
    // Interrupt status, enable and clear; set beats clear
    wire [`OSC_IRQ_W-1:0] irq_set;
    wire [`OSC_IRQ_W-1:0] irq_clr;
    assign irq_set = {fail_s & ~fail_seen_q, sw_done};
    assign irq_clr = (wr && paddr == `OSC_IRQ_CLR_OFF)
                   ? pwdata[`OSC_IRQ_W-1:0] : {`OSC_IRQ_W{1'b0}};
    always @(posedge mclk) begin
        if (!rstn) begin
            irq_stat_q <= {`OSC_IRQ_W{1'b0}};
            irq_en_q <= {`OSC_IRQ_W{1'b0}};
        end else begin
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
            if (wr && paddr == `OSC_IRQ_EN_OFF) begin
                irq_en_q <= pwdata[`OSC_IRQ_W-1:0];
            end
        end
    end
    assign irq = |(irq_stat_q & irq_en_q);

    // ======================================================
    // Read data, registered in the setup cycle
    always @(posedge mclk) begin
        if (!rstn) begin
            prdata <= 32'h0;
        end else if (rd && !penable) begin
            case (paddr)
                `OSC_CTRL_OFF: prdata <= ctrl_rd;
                `OSC_IRQ_STAT_OFF: prdata <= {30'h0, irq_stat_q};
                `OSC_IRQ_EN_OFF: prdata <= {30'h0, irq_en_q};
                `OSC_CUR_OFF: prdata <= {29'h0, active_source};
                default: prdata <= 32'h0;
            endcase
        end
    end
endmodule

// >>> logic/osc_defs.vh
// Constants for the oscillator selection control block
`ifndef OSC_DEFS_VH
`define OSC_DEFS_VH

// ======================================================
// Register byte offsets
`define OSC_CTRL_OFF 12'h000
`define OSC_UNLOCK_OFF 12'h004
`define OSC_IRQ_STAT_OFF 12'h008
`define OSC_IRQ_CLR_OFF 12'h00C
`define OSC_IRQ_EN_OFF 12'h010
`define OSC_CUR_OFF 12'h014

// ======================================================
// Control register fields
`define OSC_NSEL_HI 10
`define OSC_NSEL_LO 8
`define OSC_LOCK_BIT 7
`define OSC_SLEEP_BIT 4
`define OSC_FAIL_BIT 3
`define OSC_SEC_EN_BIT 1
`define OSC_SWREQ_BIT 0

// ======================================================
// Source codes
`define OSC_SRC_FAST_RC_POSTDIVIDER 3'h0
`define OSC_SRC_PLL 3'h1
`define OSC_SRC_PRI 3'h2
`define OSC_SRC_RSVD 3'h3
`define OSC_SRC_SEC 3'h4
`define OSC_SRC_LOW_POWER_RC_OSC 3'h5

// ======================================================
// Unlock keys, written in order to the unlock register
`define OSC_KEY1 32'hAA996655
`define OSC_KEY2 32'h556699AA

// ======================================================
// Interrupt bits
`define OSC_IRQ_SWDONE 0
`define OSC_IRQ_FAIL 1
`define OSC_IRQ_W 2

// ======================================================
// Timing
`define OSC_READY_NS 200
`define OSC_READY_CYC ((`OSC_READY_NS + 9) / 10)
`define OSC_CNT_W 8

`endif

// >>> logic/osc_sync2.v
// Two-flop synchroniser for a bus of asynchronous levels
`timescale 1ns/100ps
module osc_sync2 #(
    parameter W = 1
) (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // Data
    input wire [W-1:0] async_in,
    output reg [W-1:0] sync_out
);
    reg [W-1:0] meta_q;

    always @(posedge mclk) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            sync_out <= {W{1'b0}};
        end else begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// >>> bench/osc_select_ctrl_properties.sv
// Port checker for the oscillator selection control block
`timescale 1ns/100ps
module osc_select_ctrl_props (
    // Clock and reset
    input wire mclk,
    input wire rstn,
    // APB
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire pready,
    input wire pslverr,
    input wire [31:0] prdata,
    // Core and clock tree
    input wire wait_exec,
    input wire [2:0] active_source,
    input wire [7:0] source_run,
    input wire clk_gate_hold,
    input wire sleep_req,
    input wire idle_req
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // ====================
    // Changeover steps and bus, read and wait-mode checks
    sequence gate_window;
        ##21 clk_gate_hold ##1 !clk_gate_hold;
    endsequence
    chk_apb_ready: assert property (pready && !pslverr)
        else $error("apb answer not immediate");
    chk_read_stands: assert property ($changed(prdata) |->
        $past(psel && !penable && !pwrite))
        else $error("read data moved outside read setup");
    chk_wait_mode: assert property (rstn && wait_exec |=>
        sleep_req ^ idle_req)
        else $error("wait did not pick exactly one mode");
    chk_wait_cause: assert property ((sleep_req || idle_req) |->
        $past(wait_exec))
        else $error("mode request without wait");
    chk_gate_len: assert property ($rose(clk_gate_hold) |->
        gate_window)
        else $error("gate hold length wrong");
    chk_src_held: assert property ($changed(active_source) &&
        $past(rstn, 2) |-> $past(clk_gate_hold) || $past(clk_gate_hold, 2))
        else $error("source changed outside changeover");
    chk_old_runs: assert property (clk_gate_hold |->
        source_run[active_source])
        else $error("current source stopped during changeover");
    chk_gate_steady: assert property (clk_gate_hold &&
        $past(clk_gate_hold) |-> $stable(active_source))
        else $error("source moved while gated");
endmodule
bind osc_select_ctrl osc_select_ctrl_props u_props (.mclk(mclk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pready(pready),
    .pslverr(pslverr), .prdata(prdata), .wait_exec(wait_exec),
    .active_source(active_source), .source_run(source_run),
    .clk_gate_hold(clk_gate_hold), .sleep_req(sleep_req),
    .idle_req(idle_req));

// >>> bench/oscillator_select_control_tb.sv
// Self-checking testbench for the oscillator selection control block
`timescale 1ns/100ps
`include "osc_defs.vh"
module oscillator_select_control_tb;
    reg mclk = 1'b0;
    reg rstn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h00000000;
    reg [2:0] strap = 3'h6;
    reg sec_cfg = 1'b1;
    reg [7:0] ready = 8'hFF;
    reg fail_mon = 1'b0;
    reg wait_exec = 1'b0;
    reg w_q = 1'b0;
    wire pready, pslverr, irq, gate, sec_run, slp, idl;
    wire [31:0] prdata;
    wire [2:0] act;
    integer errors = 0, cmp_count = 0, seed = 26269, wseed = 26269;
    integer cyc = 0, i, k;
    reg [31:0] r, x;
    reg [2:0] c, cur;
    reg e, s;
    osc_select_ctrl u_dut (.mclk(mclk), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .initial_source_config(strap), .cfg_secondary_osc_enable(sec_cfg),
        .osc_ready(ready), .fail_safe_clock_monitor(fail_mon),
        .wait_exec(wait_exec), .active_source(act), .source_run(),
        .clk_gate_hold(gate), .secondary_osc_run(sec_run), .sleep_req(slp),
        .idle_req(idl), .irq(irq));
    always #5 mclk = ~mclk;
    // Copy of the wait level as the design saw it one edge ago
    always @(posedge mclk) begin
        wait_exec <= $random(wseed);
        w_q <= wait_exec;
    end
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc > 20000) begin
            errors = errors + 1;
            end_of_test;
        end
    end
    task chk(input [31:0] seen, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error at %0t: saw %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge mclk);
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1) @(posedge mclk);
            r = prdata;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Unlock is consumed by every control write
    task ctl(input [31:0] d);
        begin
            apb(1'b1, `OSC_UNLOCK_OFF, `OSC_KEY1);
            apb(1'b1, `OSC_UNLOCK_OFF, `OSC_KEY2);
            apb(1'b1, `OSC_CTRL_OFF, d);
        end
    endtask
    task rst_check;
        begin
            rstn <= 1'b0;
            repeat (3) @(posedge mclk);
            rstn <= 1'b1;
            apb(1'b0, `OSC_CTRL_OFF, 32'h0);
            chk(r, {21'h0, strap, 6'h00, sec_cfg, 1'b0});
            chk(act, dec(strap));
        end
    endtask
    function [2:0] dec(input [2:0] v);
        dec = (v > 3'h5) ? 3'h0 : v;
    endfunction
    task end_of_test;
        begin
            if (errors == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        rst_check;
        apb(1'b1, 12'h018, 32'hFFFFFFFF);
        apb(1'b0, 12'h018, 32'h0);
        chk(r, 32'h0);
        e = $random(seed);
        ctl(32'hFFFFF87C | {21'h0, strap, 6'h00, e, 1'b0});
        x = {21'h0, strap, 3'h0, 1'b1, 2'h0, e, 1'b0};
        apb(1'b0, `OSC_CTRL_OFF, 32'h0);
        chk(r, x);
        chk(sec_run, e);
        apb(1'b1, `OSC_CTRL_OFF, 32'h00000012);
        apb(1'b0, `OSC_CTRL_OFF, 32'h0);
        chk(r, x);
        apb(1'b1, `OSC_IRQ_EN_OFF, 32'h1);
        cur = dec(strap);
        for (k = 0; k < 8; k = k + 1) begin
            c = k;
            s = $random(seed);
            ready <= (k == 1) ? 8'h00 : 8'hFF;
            ctl({21'h0, c, 3'h0, s, 2'h0, e, k != 3});
            if (k == 1) begin
                repeat (40) @(posedge mclk);
                chk(act, cur);
                ready <= 8'hFF;
            end
            i = 0;
            r = 32'h1;
            while (r[0] === 1'b1 && i < 80) begin
                apb(1'b0, `OSC_CTRL_OFF, 32'h0);
                i = i + 1;
            end
            chk(r[10:0], {c, 3'h0, s, 2'h0, e, 1'b0});
            @(posedge mclk);
            chk({slp, idl}, {w_q & s, w_q & ~s});
            if (k != 3) cur = dec(c);
            chk(act, cur);
            apb(1'b0, `OSC_CUR_OFF, 32'h0);
            chk(r, {29'h0, cur});
        end
        chk(irq, 1'b1);
        apb(1'b1, `OSC_IRQ_CLR_OFF, 32'h1);
        apb(1'b0, `OSC_IRQ_STAT_OFF, 32'h0);
        chk(irq, 1'b0);
        fail_mon <= 1'b1;
        apb(1'b1, `OSC_IRQ_EN_OFF, 32'h0);
        apb(1'b0, `OSC_CTRL_OFF, 32'h0);
        chk(r[3], 1'b1);
        chk(irq, 1'b0);
        apb(1'b1, `OSC_IRQ_EN_OFF, 32'h2);
        apb(1'b0, `OSC_IRQ_STAT_OFF, 32'h0);
        chk(r[1:0], 2'h2);
        chk(irq, 1'b1);
        ctl({21'h0, 3'h2, 8'h80});
        ctl({21'h0, 3'h5, 8'h01});
        repeat (40) @(posedge mclk);
        apb(1'b0, `OSC_CTRL_OFF, 32'h0);
        chk({r[10:7], r[0]}, 5'h0A);
        chk(act, cur);
        fail_mon <= 1'b0;
        strap <= 3'h7;
        rst_check;
        end_of_test;
    end
endmodule
